/* tb/spf_peer.sv */
module spf_peer (
	input wire sck_i, // serial clock
	input wire mosi_i, // data from master
	input wire sel_b_i, // select, active low
	input wire [7:0] tx_i, // answer byte
	output wire miso_o, // data to master
	output logic [7:0] rx_o // bytes seen
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh = 8'h00;
	logic lst = 1'b0;
	initial rx_o = 8'h00;
	// mode 0 slave: capture on rising, shift on falling
	always @(negedge sel_b_i) sh = tx_i;
	always @(posedge sel_b_i) lst = sh[7];
	always @(posedge sck_i) if (!sel_b_i) rx_o <= {rx_o[6:0], mosi_i};
	always @(negedge sck_i) if (!sel_b_i) sh <= {sh[6:0], 1'b0};
	assign miso_o = sel_b_i ? ~lst : sh[7];
endmodule // spf_peer

/* tb/spf_top_asserts.sv */
module spf_top_asserts (
	input wire mclk_i, // cpu clock
	input wire rst_b_i, // reset, active low
	input wire [7:0] addr_i, // register address
	input wire rd_i, // read strobe
	input wire [7:0] rdata_o, // read data
	input wire cpu_irq_mask_i, // cpu mask
	input wire halt_i, // halt mode
	input wire irq_o, // interrupt
	input wire wake_o, // wake request
	input wire spi_active_o, // port enable
	input wire ss_b_i, // select pin
	input wire sck_o, // clock out
	input wire sck_oe_o, // clock enable
	input wire mosi_oe_o, // mosi enable
	input wire miso_oe_o // miso enable
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// ----------------------------------------
	// pin and request relations
	// ----------------------------------------
	AST_WAKE: assert property (wake_o == (irq_o && !halt_i))
		else $error("wake differs from unhalted irq");
	AST_MASK: assert property (cpu_irq_mask_i |-> !irq_o)
		else $error("irq while masked");
	AST_PORT: assert property (!spi_active_o |-> !sck_oe_o && !mosi_oe_o && !miso_oe_o)
		else $error("pin driven while port off");
	AST_MOSI: assert property (mosi_oe_o |-> sck_oe_o)
		else $error("mosi driven outside master");
	AST_MISO: assert property (miso_oe_o |-> !sck_oe_o)
		else $error("miso driven in master");
	AST_FAULT: assert property (sck_oe_o && !ss_b_i |-> ##[1:5] !spi_active_o && !sck_oe_o)
		else $error("no fault on select low");
	AST_HALT: assert property (halt_i && $past(halt_i) |-> $stable(sck_o))
		else $error("clock moved in halt");
	AST_RDATA: assert property (!$past(rd_i) || $past(addr_i) > 8'h72 |-> rdata_o == 8'h00)
		else $error("read data outside valid read");
endmodule // spf_top_asserts

/* tb/spf_top_tb.sv */
module spf_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk_i = 0, rst_b_i = 0, wr_s = 0, rd_s = 0, mask = 0, halt = 0;
	logic ss_b = 1, sck_m = 0, mosi_m = 0, sel_b = 1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, ptx = 8'h00;
	wire [7:0] rdata_o, prx;
	wire irq_o, wake_o, act, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_oe_o, pmiso;
	int error_cnt = 0, n_tests = 0;
	int dv[6] = '{4, 8, 16, 32, 64, 128};
	logic [7:0] rc[6] = '{8'h20, 8'h00, 8'h01, 8'h22, 8'h02, 8'h03};
	initial forever #2 mclk_i = ~mclk_i;
	spf_top dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata_o), .cpu_irq_mask_i(mask),
		.halt_i(halt), .irq_o(irq_o), .wake_o(wake_o), .spi_active_o(act), .ss_b_i(ss_b),
		.sck_i(sck_m), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_m), .mosi_o(mosi_o),
		.mosi_oe_o(mosi_oe_o), .miso_i(pmiso), .miso_o(), .miso_oe_o(miso_oe_o));
	spf_peer peer (.sck_i(sck_o), .mosi_i(mosi_o), .sel_b_i(sel_b), .tx_i(ptx),
		.miso_o(pmiso), .rx_o(prx));
	// ----------------------------------------
	// bus and link tasks
	// ----------------------------------------
	task end_sim;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input [7:0] g, input [7:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge mclk_i);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge mclk_i);
		wr_s <= 1'b0;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		@(posedge mclk_i);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk_i);
		rd_s <= 1'b0;
		#1 chk(rdata_o, e);
	endtask
	task wt(input int lo, input int hi);
		int n;
		n = 0;
		while (irq_o !== 1'b1 && n < 3000) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		chk(8'(n >= lo && n <= hi), 8'h01);
	endtask
	task xf(input [7:0] t, input [7:0] p, input int d);
		ptx = p;
		@(posedge mclk_i);
		sel_b <= 1'b0;
		wr(8'h70, t);
		wt(8 * d - 2, 8 * d + 6);
		sel_b <= 1'b1;
		rd(8'h72, 8'h80);
		rd(8'h70, p);
		chk(prx, t);
	endtask
	task sb(input [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			mosi_m <= b[i];
			repeat (8) @(posedge mclk_i);
			sck_m <= 1'b1;
			repeat (8) @(posedge mclk_i);
			sck_m <= 1'b0;
		end
		repeat (8) @(posedge mclk_i);
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge mclk_i);
		error_cnt++;
		end_sim;
	end
	initial begin
		repeat (4) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		rd(8'h71, 8'h00);
		rd(8'h72, 8'h00);
		rd(8'hA0, 8'h00);
		wr(8'h71, 8'h58);
		repeat (2) @(posedge mclk_i);
		chk({7'h00, sck_o}, 8'h01);
		wr(8'h71, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(8'h71, 8'hD0 | rc[i]);
			xf(8'hA5 ^ 8'(i), 8'h3C + 8'(i), dv[i]);
		end
		// collision, then halt in mid byte
		ptx = 8'h96;
		sel_b <= 1'b0;
		wr(8'h70, 8'h5A);
		wr(8'h70, 8'hFF);
		halt <= 1'b1;
		repeat (100) @(posedge mclk_i);
		halt <= 1'b0;
		wt(1015, 1030);
		mask <= 1'b1;
		repeat (2) @(posedge mclk_i);
		mask <= 1'b0;
		sel_b <= 1'b1;
		rd(8'h72, 8'hC0);
		rd(8'h70, 8'h96);
		chk(prx, 8'h5A);
		rd(8'h72, 8'h00);
		// mode fault with select kept high while clearing
		ss_b <= 1'b0;
		repeat (8) @(posedge mclk_i);
		ss_b <= 1'b1;
		rd(8'h71, 8'h83);
		wr(8'h71, 8'hD0);
		rd(8'h71, 8'h80);
		chk({7'h00, irq_o}, 8'h01);
		rd(8'h72, 8'h10);
		wr(8'h71, 8'hD0);
		rd(8'h71, 8'hD0);
		rd(8'h72, 8'h00);
		// slave reception, two bytes without clearing
		wr(8'h71, 8'hC0);
		ss_b <= 1'b0;
		sb(8'hC3);
		sb(8'h3E);
		ss_b <= 1'b1;
		rd(8'h72, 8'hA0);
		rd(8'h70, 8'hC3);
		rd(8'h72, 8'h00);
		end_sim;
	end
endmodule // spf_top_tb
bind spf_top spf_top_asserts u_chk (.mclk_i, .rst_b_i, .addr_i, .rd_i, .rdata_o,
	.cpu_irq_mask_i, .halt_i, .irq_o, .wake_o, .spi_active_o, .ss_b_i, .sck_o, .sck_oe_o,
	.mosi_oe_o, .miso_oe_o);

/* verilog/spf_map.vh */
`ifndef SPF_MAP_VH
`define SPF_MAP_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define SPF_ADDR_DATA 8'h70
`define SPF_ADDR_CTRL 8'h71
`define SPF_ADDR_STAT 8'h72

// ----------------------------------------
// spi_control field positions
// ----------------------------------------
`define SPF_CR_IRQ_EN 7
`define SPF_CR_PORT_EN 6
`define SPF_CR_RATE_HALF 5
`define SPF_CR_MASTER 4
`define SPF_CR_IDLE_POL 3
`define SPF_CR_CAP_PHASE 2
`define SPF_CR_RATE_HI 1
`define SPF_CR_RATE_LO 0

// ----------------------------------------
// spi_status_control field positions
// ----------------------------------------
`define SPF_SR_TDONE 7
`define SPF_SR_WRITE_COLLISION_FLAG 6
`define SPF_SR_OVR 5
`define SPF_SR_MODE_FAULT_FLAG 4
`define SPF_SR_OUT_DIS 2
`define SPF_SR_SS_SOFT 1
`define SPF_SR_SS_LEVEL 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define SPF_CTRL_RST 8'h00
`define SPF_STAT_RST 8'h00

// ----------------------------------------
// master clock divider, half period minus one
// ----------------------------------------
`define SPF_HALF_DIV4 6'h01
`define SPF_HALF_DIV8 6'h03
`define SPF_HALF_DIV16 6'h07
`define SPF_HALF_DIV32 6'h0F
`define SPF_HALF_DIV64 6'h1F
`define SPF_HALF_DIV128 6'h3F

// ----------------------------------------
// bit transfer
// ----------------------------------------
`define SPF_LAST_EDGE 4'hF
`define SPF_PIN_COUNT 4

`endif

/* verilog/spf_top.v */
// Our own choices: the plain strobed port and the placing of the registers.
`include "spf_map.vh"

module spf_top (
	input wire mclk_i, // cpu clock
	input wire rst_b_i, // synchronous reset, active low
	input wire clk_en_i, // freezes all state while low
	input wire [7:0] addr_i, // register address
	input wire [7:0] wdata_i, // write data
	input wire wr_i, // write strobe
	input wire rd_i, // read strobe
	output wire [7:0] rdata_o, // read data, cycle after strobe
	input wire cpu_irq_mask_i, // cpu interrupt mask, high masks
	input wire halt_i, // cpu in halt mode
	output wire irq_o, // interrupt request
	output wire wake_o, // wake request out of wait mode
	output wire spi_active_o, // pins carry spi functions
	input wire ss_b_i, // slave select pin, active low
	input wire sck_i, // serial clock pin in
	output wire sck_o, // serial clock pin out
	output wire sck_oe_o, // serial clock drive enable
	input wire mosi_i, // mosi pin in
	output wire mosi_o, // mosi pin out
	output wire mosi_oe_o, // mosi drive enable
	input wire miso_i, // miso pin in
	output wire miso_o, // miso pin out
	output wire miso_oe_o // miso drive enable
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	wire [`SPF_PIN_COUNT-1:0] pin_raw;
	wire [`SPF_PIN_COUNT-1:0] pin_sync;
	assign pin_raw = {ss_b_i, sck_i, mosi_i, miso_i};

	genvar g;
	generate
		for (g = 0; g < `SPF_PIN_COUNT; g = g + 1) begin : g_sync
			reg s1_q;
			reg s2_q;
			always @(posedge mclk_i) begin
				if (!rst_b_i) begin
					s1_q <= 1'b1;
					s2_q <= 1'b1;
				end else if (clk_en_i) begin
					s1_q <= pin_raw[g];
					s2_q <= s1_q;
				end
			end
			assign pin_sync[g] = s2_q;
		end
	endgenerate

	wire ss_pin = pin_sync[3];
	wire sck_pin = pin_sync[2];
	wire mosi_pin = pin_sync[1];
	wire miso_pin = pin_sync[0];

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg irq_en_q;
	reg port_en_q;
	reg rate_half_q;
	reg master_q;
	reg idle_pol_q;
	reg cap_phase_q;
	reg [1:0] rate_sel_q;
	reg tdone_q;
	reg write_collision_flag_q;
	reg ovr_q;
	reg mode_fault_flag_q;
	reg out_dis_q;
	reg ss_soft_q;
	reg ss_level_q;
	reg tdone_arm_q;
	reg write_collision_flag_arm_q;
	reg mode_fault_flag_arm_q;
	reg [7:0] shift_q;
	reg [7:0] rxbuf_q;
	reg [7:0] rdata_q;
	reg out_q;
	reg sck_q;
	reg sck_prev_q;
	reg busy_q;
	reg [3:0] edge_q;
	reg [5:0] div_q;
	reg mcap_q;
	reg mdone_q;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire dr_wr = wr_i & (addr_i == `SPF_ADDR_DATA);
	wire dr_rd = rd_i & (addr_i == `SPF_ADDR_DATA);
	wire cr_wr = wr_i & (addr_i == `SPF_ADDR_CTRL);
	wire cs_wr = wr_i & (addr_i == `SPF_ADDR_STAT);
	wire cs_rd = rd_i & (addr_i == `SPF_ADDR_STAT);
	wire cs_acc = cs_wr | cs_rd;

	// ----------------------------------------
	// mode fault and transfer events
	// ----------------------------------------
	wire ss_int = ss_soft_q ? ss_level_q : ss_pin;
	wire fault = master_q & ~ss_int;
	wire slv_sel = port_en_q & ~master_q & ~ss_int;
	wire mst_tick = busy_q & master_q & (div_q == 6'h00) & ~halt_i;
	wire sck_edge = sck_pin ^ sck_prev_q;
	wire evt = master_q ? mst_tick : (slv_sel & sck_edge);
	wire sample = evt & (edge_q[0] == cap_phase_q);
	wire drive = evt & ~sample;
	wire edge_last = evt & (edge_q == `SPF_LAST_EDGE);
	// master takes miso one cycle after its edge: the pin synchroniser lags two cycles
	wire complete = master_q ? mdone_q : edge_last;
	wire cap_now = master_q ? mcap_q : sample;
	wire in_bit = master_q ? miso_pin : mosi_pin;
	wire [7:0] shift_smp = {shift_q[6:0], in_bit};
	wire [7:0] rx_byte = cap_now ? shift_smp : shift_q;

	// slave with phase 0 counts the whole selected time as a transfer
	wire slv_act = cap_phase_q ? (slv_sel & (edge_q != 4'h0)) : slv_sel;
	wire xfer_act = master_q ? busy_q : slv_act;
	wire dr_blocked = tdone_q & ~tdone_arm_q;
	wire dr_take = dr_wr & ~xfer_act & ~dr_blocked;
	wire mst_start = dr_take & master_q & port_en_q;

	reg [5:0] half_w;
	always @* begin
		case ({rate_half_q, rate_sel_q})
		3'b100: half_w = `SPF_HALF_DIV4;
		3'b000: half_w = `SPF_HALF_DIV8;
		3'b001: half_w = `SPF_HALF_DIV16;
		3'b110: half_w = `SPF_HALF_DIV32;
		3'b010: half_w = `SPF_HALF_DIV64;
		3'b011: half_w = `SPF_HALF_DIV128;
		default: half_w = `SPF_HALF_DIV128;
		endcase
	end

	// ----------------------------------------
	// flags
	// ----------------------------------------
	wire tdone_d = complete | (tdone_q & ~(tdone_arm_q & (dr_rd | dr_wr)));
	wire tdone_arm_d = ~complete & tdone_d & (tdone_arm_q | (cs_acc & tdone_q));
	wire ovr_d = (complete & tdone_q) | (ovr_q & ~cs_rd);
	wire write_collision_flag_set = dr_wr & xfer_act;
	wire write_collision_flag_d = write_collision_flag_set | (write_collision_flag_q & ~(write_collision_flag_arm_q & dr_rd));
	wire write_collision_flag_arm_d = ~write_collision_flag_set & write_collision_flag_d & (write_collision_flag_arm_q | (cs_rd & write_collision_flag_q));
	wire mode_fault_flag_d = fault | (mode_fault_flag_q & ~(mode_fault_flag_arm_q & cr_wr));
	wire mode_fault_flag_arm_d = ~fault & mode_fault_flag_d & (mode_fault_flag_arm_q | (cs_rd & mode_fault_flag_q));

	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			tdone_q <= 1'b0;
			tdone_arm_q <= 1'b0;
			ovr_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			write_collision_flag_arm_q <= 1'b0;
			mode_fault_flag_q <= 1'b0;
			mode_fault_flag_arm_q <= 1'b0;
			rxbuf_q <= 8'h00;
		end else if (clk_en_i) begin
			tdone_q <= tdone_d;
			tdone_arm_q <= tdone_arm_d;
			ovr_q <= ovr_d;
			write_collision_flag_q <= write_collision_flag_d;
			write_collision_flag_arm_q <= write_collision_flag_arm_d;
			mode_fault_flag_q <= mode_fault_flag_d;
			mode_fault_flag_arm_q <= mode_fault_flag_arm_d;
			if (complete & ~tdone_q) begin
				rxbuf_q <= rx_byte;
			end
		end
	end

	// ----------------------------------------
	// control and status registers
	// ----------------------------------------
	wire mode_fault_flag_lock = mode_fault_flag_q & ~mode_fault_flag_arm_q;
	wire port_en_w = mode_fault_flag_lock ? (wdata_i[`SPF_CR_PORT_EN] & port_en_q) :
		wdata_i[`SPF_CR_PORT_EN];
	wire master_w = mode_fault_flag_lock ? (wdata_i[`SPF_CR_MASTER] & master_q) :
		wdata_i[`SPF_CR_MASTER];

	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			irq_en_q <= 1'b0;
			port_en_q <= 1'b0;
			rate_half_q <= 1'b0;
			master_q <= 1'b0;
			idle_pol_q <= 1'b0;
			cap_phase_q <= 1'b0;
			rate_sel_q <= 2'h0;
			out_dis_q <= 1'b0;
			ss_soft_q <= 1'b0;
			ss_level_q <= 1'b0;
		end else if (clk_en_i) begin
			if (cr_wr) begin
				irq_en_q <= wdata_i[`SPF_CR_IRQ_EN];
				port_en_q <= port_en_w;
				rate_half_q <= wdata_i[`SPF_CR_RATE_HALF];
				master_q <= master_w;
				idle_pol_q <= wdata_i[`SPF_CR_IDLE_POL];
				cap_phase_q <= wdata_i[`SPF_CR_CAP_PHASE];
				rate_sel_q <= wdata_i[`SPF_CR_RATE_HI:`SPF_CR_RATE_LO];
			end
			if (fault) begin
				port_en_q <= 1'b0;
				master_q <= 1'b0;
			end
			if (cs_wr) begin
				out_dis_q <= wdata_i[`SPF_SR_OUT_DIS];
				ss_soft_q <= wdata_i[`SPF_SR_SS_SOFT];
				ss_level_q <= wdata_i[`SPF_SR_SS_LEVEL];
			end
		end
	end

	// ----------------------------------------
	// shift engine
	// ----------------------------------------
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			shift_q <= 8'h00;
			out_q <= 1'b0;
			sck_q <= 1'b0;
			sck_prev_q <= 1'b0;
			busy_q <= 1'b0;
			edge_q <= 4'h0;
			div_q <= 6'h00;
			mcap_q <= 1'b0;
			mdone_q <= 1'b0;
		end else if (clk_en_i) begin
			sck_prev_q <= sck_pin;
			mcap_q <= sample & master_q & ~fault;
			mdone_q <= edge_last & master_q & ~fault;
			if (dr_take) begin
				shift_q <= wdata_i;
				out_q <= wdata_i[7];
			end
			if (fault | ~port_en_q) begin
				busy_q <= 1'b0;
				edge_q <= 4'h0;
				sck_q <= idle_pol_q;
			end else if (mst_start) begin
				busy_q <= 1'b1;
				edge_q <= 4'h0;
				div_q <= half_w;
			end else if (~master_q & ss_int) begin
				edge_q <= 4'h0;
				if (~dr_take) begin
					out_q <= shift_q[7];
				end
			end else if (evt) begin
				edge_q <= edge_q + 4'h1;
				if (master_q) begin
					sck_q <= ~sck_q;
					div_q <= half_w;
				end
				if (sample & ~master_q) begin
					shift_q <= shift_smp;
				end
				if (drive) begin
					out_q <= shift_q[7];
				end
			end else if (busy_q & ~halt_i) begin
				div_q <= div_q - 6'h01;
			end
			if (master_q & mcap_q) begin
				shift_q <= shift_smp;
			end
			if (complete) begin
				busy_q <= 1'b0;
			end
			if (~busy_q & ~(mst_start)) begin
				sck_q <= idle_pol_q;
			end
		end
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			rdata_q <= 8'h00;
		end else if (clk_en_i) begin
			if (dr_rd) begin
				rdata_q <= rxbuf_q;
			end else if (rd_i & (addr_i == `SPF_ADDR_CTRL)) begin
				rdata_q <= {irq_en_q, port_en_q, rate_half_q, master_q,
					idle_pol_q, cap_phase_q, rate_sel_q};
			end else if (cs_rd) begin
				rdata_q <= {tdone_q, write_collision_flag_q, ovr_q, mode_fault_flag_q, 1'b0,
					out_dis_q, ss_soft_q, ss_level_q};
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end

	assign rdata_o = rdata_q;

	// ----------------------------------------
	// interrupt and pins
	// ----------------------------------------
	wire irq_req = irq_en_q & (tdone_q | mode_fault_flag_q | ovr_q);
	assign irq_o = irq_req & ~cpu_irq_mask_i;
	assign wake_o = irq_o & ~halt_i;

	assign spi_active_o = port_en_q;
	assign sck_o = sck_q;
	assign sck_oe_o = port_en_q & master_q;
	assign mosi_o = out_q;
	assign mosi_oe_o = port_en_q & master_q & ~out_dis_q;
	assign miso_o = out_q;
	assign miso_oe_o = port_en_q & ~master_q & ~out_dis_q & ~ss_int;

endmodule // spf_top
